/* core/smpc_pkg.sv */
// Purpose: Shared constants for the sleep mode power controller.
// Assumes: One 10 MHz system clock; module indices fixed below.
// Notes:   Start-up times are plain defaults, to be tuned per board.

package smpc_pkg;

    // ------------------------------------------------------------
    // Clock and module map
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int NUM_MOD       = 8;
    localparam int GPIO_W        = 16;

    // Module slots behind each clock enable
    localparam int MOD_CHANGE = 0;  // Input-change detection pins
    localparam int MOD_WDOG   = 1;  // watchdog_counter
    localparam int MOD_CONV   = 2;  // Analog converter
    localparam int MOD_SERIAL = 3;  // Serial port
    localparam int MOD_CAL    = 4;  // calendar_clock_module
    localparam int MOD_TIMER  = 5;  // first_general_timer
    localparam int MOD_CAPT   = 6;  // Input capture, external clock
    localparam int MOD_OTHER  = 7;  // System-clocked peripheral

    // Slots that may run and wake the part while asleep
    localparam logic [NUM_MOD-1:0] WAKE_MASK_DEF = 8'h7F;

    // ------------------------------------------------------------
    // Oscillator select and start-up times
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SMPC_OSC_FAST_RC = 2'h0,
        SMPC_OSC_PRIMARY = 2'h1,
        SMPC_OSC_SECOND  = 2'h2,
        SMPC_OSC_LOW_RC  = 2'h3
    } smpc_osc_t;

    localparam int FAST_RC_START_NS = 200;
    localparam int PRIMARY_START_NS = 2000;
    localparam int SECOND_START_NS  = 3000;
    localparam int LOW_RC_START_NS  = 500;

    // Least times round up to whole cycles
    localparam int FAST_RC_START_CYC =
        (FAST_RC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PRIMARY_START_CYC =
        (PRIMARY_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SECOND_START_CYC =
        (SECOND_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOW_RC_START_CYC =
        (LOW_RC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int START_CNT_W = 8;

    // ------------------------------------------------------------
    // Controller states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SMPC_ST_RUN   = 3'h1,
        SMPC_ST_SLEEP = 3'h2,
        SMPC_ST_WAKE  = 3'h4
    } smpc_state_t;

    // Reset values
    localparam logic [NUM_MOD-1:0] DIS_RST  = 8'h00;
    localparam logic [1:0]         OSC_RST  = 2'h0;

endpackage

/* core/smpc_sync.sv */
// Purpose: Two-flop synchroniser for levels from other domains.
// Assumes: Each bit is an independent slow level or stretched event.
// Notes:   First stage feeds only the second stage.

module smpc_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             arst_n,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    generate
        if (WIDTH < 1) begin : g_chk
            $error("smpc_sync: WIDTH must be at least 1");
        end
    endgenerate

    // Two stages; metastability settles in the first
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule

/* core/smpc_delay.sv */
// Purpose: Down counter timing the oscillator start-up on wake.
// Assumes: start is a one-cycle pulse; load is at least one.
// Notes:   done is high whenever the counter is idle at zero.

module smpc_delay #(
    parameter int CW = 8
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          arst_n,
    // Control
    input  wire logic          start,
    input  wire logic [CW-1:0] load,
    output logic               done
);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          zero;

    generate
        if (CW < 2) begin : g_chk
            $error("smpc_delay: CW must be at least 2");
        end
    endgenerate

    // Load on start, else count down to zero and hold
    assign zero  = (cnt_q == '0);
    assign cnt_d = start ? load : (zero ? cnt_q : cnt_q - 1'b1);
    assign done  = zero;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule

/* core/smpc_core.sv */
// Purpose: Sleep mode power controller: entry, hold and wake sequence.
// Assumes: sleep_req and software controls come from this clock domain;
//          wake events and the brown-out trip arrive asynchronously.
// Notes:   Clock enables are levels for the clock gates of each slot.

// Operation
// - Sleep entry halts the core and gates every slot not able to wake.
// - In sleep the system oscillator stops unless bus scaling holds it.
// - Wake waits a start-up delay chosen by the selected oscillator.
// - The clock failure monitor is held off for the whole sleep stay.
// - An enabled brown-out detector stays live and acts while asleep.
// - Entering sleep never clears the watchdog count by itself.
// - Change pins, watchdog, converter, serial and slow-clocked slots run.
// - An event from a running wake-capable slot returns the part to run.
// - General pins keep their output levels and drive during sleep.
// - Software can disable each slot before entry and it stays off.
module smpc_core
    import smpc_pkg::*;
#(
    parameter int                  N_MOD     = NUM_MOD,
    parameter int                  PIN_W     = GPIO_W,
    parameter logic [NUM_MOD-1:0]  WAKE_MASK = WAKE_MASK_DEF
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             arst_n,
    // Core request and software controls
    input  wire logic             sleep_req,
    input  wire logic [N_MOD-1:0] mod_disable,
    input  wire logic [1:0]       osc_sel,
    input  wire logic             pb_keep_clk,
    input  wire logic             bor_en,
    input  wire logic             wdt_en,
    input  wire logic             wdt_clear_req,
    // Events from the slots and the supply
    input  wire logic [N_MOD-1:0] wake_evt,
    input  wire logic             bor_trip,
    // General pin levels from the port logic
    input  wire logic [PIN_W-1:0] gpio_level,
    input  wire logic [PIN_W-1:0] gpio_drive,
    // Power and clock controls
    output logic                  cpu_halt,
    output logic                  in_sleep,
    output logic                  sysclk_src_en,
    output logic                  clock_failure_monitor_en,
    output logic [N_MOD-1:0]      periph_clk_en,
    // Watchdog and brown-out
    output logic                  wdt_run,
    output logic                  wdt_clear,
    output logic                  bor_reset,
    output logic                  wake_pulse,
    // Pin outputs
    output logic [PIN_W-1:0]      gpio_pin_out,
    output logic [PIN_W-1:0]      gpio_pin_oe
);

    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    generate
        if (N_MOD != NUM_MOD) begin : g_chk_mod
            $error("smpc_core: N_MOD must match the slot map");
        end
        if (PIN_W < 1) begin : g_chk_pin
            $error("smpc_core: PIN_W must be at least 1");
        end
        // Counter must hold every start-up count and never load zero
        if ((FAST_RC_START_CYC < 1) || (LOW_RC_START_CYC < 1)
            || (PRIMARY_START_CYC >= 2**START_CNT_W)
            || (SECOND_START_CYC >= 2**START_CNT_W)) begin : g_chk_cnt
            $error("smpc_core: start-up counts do not fit the counter");
        end
    endgenerate

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    smpc_state_t            state_q;
    smpc_state_t            state_d;
    logic [N_MOD-1:0]       dis_q;
    logic [1:0]             osc_q;
    logic                   bor_reset_q;
    logic                   wdt_clear_q;
    logic                   wake_pulse_q;
    logic [PIN_W-1:0]       pin_out_q;
    logic [PIN_W-1:0]       pin_oe_q;
    logic [N_MOD-1:0]       wake_sync;
    logic                   bor_sync;
    logic                   st_run;
    logic                   st_sleep;
    logic                   st_wake;
    logic                   enter;
    logic [N_MOD-1:0]       wake_live;
    logic                   wake_hit;
    logic                   dly_done;
    logic [START_CNT_W-1:0] start_load;
    logic [N_MOD-1:0]       run_en;

    // ------------------------------------------------------------
    // Input crossings
    // ------------------------------------------------------------
    // Slot events may come from external or low-power clocks
    smpc_sync #(
        .WIDTH    (N_MOD)
    ) u_wake_sync (
        .clk      (clk),
        .arst_n   (arst_n),
        .async_in (wake_evt),
        .sync_out (wake_sync)
    );

    // Brown-out comparator is analog and asynchronous
    smpc_sync #(
        .WIDTH    (1)
    ) u_bor_sync (
        .clk      (clk),
        .arst_n   (arst_n),
        .async_in (bor_trip),
        .sync_out (bor_sync)
    );

    // ------------------------------------------------------------
    // State decode
    // ------------------------------------------------------------
    assign st_run   = (state_q == SMPC_ST_RUN);
    assign st_sleep = (state_q == SMPC_ST_SLEEP);
    assign st_wake  = (state_q == SMPC_ST_WAKE);
    assign enter    = st_run && sleep_req;

    // Only slots that keep running and are not disabled may wake
    assign wake_live = wake_sync & WAKE_MASK & ~dis_q;
    assign wake_hit  = st_sleep && (wake_live != '0);

    // ------------------------------------------------------------
    // Start-up delay per oscillator
    // ------------------------------------------------------------
    // Selected source is frozen at entry so a late change cannot
    // shorten the wait of the running wake sequence
    assign start_load =
        (osc_q == SMPC_OSC_PRIMARY) ? START_CNT_W'(PRIMARY_START_CYC) :
        (osc_q == SMPC_OSC_SECOND)  ? START_CNT_W'(SECOND_START_CYC)  :
        (osc_q == SMPC_OSC_LOW_RC)  ? START_CNT_W'(LOW_RC_START_CYC)  :
                                      START_CNT_W'(FAST_RC_START_CYC);

    smpc_delay #(
        .CW     (START_CNT_W)
    ) u_delay (
        .clk    (clk),
        .arst_n (arst_n),
        .start  (wake_hit),
        .load   (start_load),
        .done   (dly_done)
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Next state: run, sleep, then oscillator start-up on wake
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            SMPC_ST_RUN: begin
                if (sleep_req) begin
                    state_d = SMPC_ST_SLEEP;
                end
            end
            SMPC_ST_SLEEP: begin
                if (wake_hit) begin
                    state_d = SMPC_ST_WAKE;
                end
            end
            SMPC_ST_WAKE: begin
                if (dly_done) begin
                    state_d = SMPC_ST_RUN;
                end
            end
            default: begin
                state_d = SMPC_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= SMPC_ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // Software settings captured while running
    // ------------------------------------------------------------
    // Disables follow software in run and are frozen while asleep,
    // since no code runs there to change them
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dis_q <= DIS_RST;
            osc_q <= OSC_RST;
        end else if (st_run) begin
            dis_q <= mod_disable;
            osc_q <= osc_sel;
        end
    end

    // ------------------------------------------------------------
    // Clock and power controls
    // ------------------------------------------------------------
    // Core is held through sleep and the whole start-up wait
    assign cpu_halt = !st_run;
    assign in_sleep = st_sleep;

    // Oscillator restarts as soon as the wake sequence begins
    assign sysclk_src_en = st_run || st_wake || pb_keep_clk;

    // Monitor would flag the stopped oscillator as a failure
    assign clock_failure_monitor_en = st_run;

    // Per-slot enables: all enabled slots run in run; in sleep and wake only wake slots
    genvar gi;
    generate
        for (gi = 0; gi < N_MOD; gi++) begin : g_slot
            assign run_en[gi] = st_run || WAKE_MASK[gi];
            assign periph_clk_en[gi] = run_en[gi] && !dis_q[gi];
        end
    endgenerate

    // ------------------------------------------------------------
    // Watchdog, brown-out and wake report
    // ------------------------------------------------------------
    // Watchdog keeps counting in sleep; only software clears it
    assign wdt_run = wdt_en && !dis_q[MOD_WDOG];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wdt_clear_q  <= 1'b0;
            bor_reset_q  <= 1'b0;
            wake_pulse_q <= 1'b0;
        end else begin
            wdt_clear_q  <= wdt_clear_req && st_run && !sleep_req;
            bor_reset_q  <= bor_en && bor_sync;
            wake_pulse_q <= wake_hit;
        end
    end

    assign wdt_clear  = wdt_clear_q;
    assign bor_reset  = bor_reset_q;
    assign wake_pulse = wake_pulse_q;

    // ------------------------------------------------------------
    // General pins
    // ------------------------------------------------------------
    // Port logic state is retained, so pins pass through one register stage in
    // every state; nothing here forces them low or off in sleep
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_out_q <= '0;
            pin_oe_q  <= '0;
        end else begin
            pin_out_q <= gpio_level;
            pin_oe_q  <= gpio_drive;
        end
    end

    assign gpio_pin_out = pin_out_q;
    assign gpio_pin_oe  = pin_oe_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    localparam int WAKE_MAX = 40;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    core_halt_a: assert property (
        enter |=> cpu_halt && in_sleep
            && ((periph_clk_en & ~WAKE_MASK) == '0))
        else $error("core or plain slot still running after entry");

    osc_stop_a: assert property (
        in_sleep && !pb_keep_clk |-> !sysclk_src_en)
        else $error("system oscillator running in sleep");

    start_wait_a: assert property (
        wake_hit && (osc_q == SMPC_OSC_PRIMARY)
            |=> cpu_halt [*8])
        else $error("core freed before primary start-up");

    monitor_off_a: assert property (
        !st_run |-> !clock_failure_monitor_en)
        else $error("clock monitor active out of run");

    brownout_live_a: assert property (
        in_sleep && bor_en && bor_sync |=> bor_reset)
        else $error("brown-out ignored in sleep");

    wdog_noclear_a: assert property (
        enter |=> !wdt_clear ##1 !wdt_clear)
        else $error("watchdog cleared by sleep entry");

    wake_slots_a: assert property (
        in_sleep |-> periph_clk_en == (WAKE_MASK & ~dis_q))
        else $error("wake slot enables wrong in sleep");

    wake_exit_a: assert property (
        wake_hit |=> st_wake && sysclk_src_en && wake_pulse)
        else $error("wake event did not start wake");

    pins_kept_a: assert property (
        in_sleep |=> (gpio_pin_out == $past(gpio_level))
            && (gpio_pin_oe == $past(gpio_drive)))
        else $error("pin level or drive changed by sleep");

    slot_off_a: assert property (
        (periph_clk_en & dis_q) == '0)
        else $error("disabled slot clocked");

    wake_order_a: assert property (
        wake_hit |=> cpu_halt ##[1:WAKE_MAX] !cpu_halt)
        else $error("core not freed after start-up");

endmodule

/* sim/test_smpc_core.sv */
// Purpose: Self-checking bench for the sleep mode power controller.
// Assumes: Default slot map and start-up times of the shared package.
// Notes:   Random settings per sleep round; pins are checked every cycle.

`define CHK(g, e) chk(32'(g), 32'(e))

module test_smpc_core
    import smpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic              clk = 1'b0;
    logic              arst_n;
    logic              sleep_req;
    logic [7:0]        mod_disable;
    logic [1:0]        osc_sel;
    logic              pb_keep_clk;
    logic              bor_en;
    logic              wdt_en;
    logic              wdt_clear_req;
    logic [7:0]        wake_evt;
    logic              bor_trip;
    logic [15:0]       gpio_level;
    logic [15:0]       gpio_drive;
    logic              cpu_halt;
    logic              in_sleep;
    logic              sysclk_src_en;
    logic              clock_failure_monitor_en;
    logic [7:0]        periph_clk_en;
    logic              wdt_run;
    logic              wdt_clear;
    logic              bor_reset;
    logic              wake_pulse;
    logic [15:0]       gpio_pin_out;
    logic [15:0]       gpio_pin_oe;
    logic [15:0]       lv_q;
    logic [15:0]       dv_q;
    logic              pin_chk = 1'b0;
    int                n_fail = 0;
    int                n_compared = 0;

    // 10 MHz clock
    always #50 clk = ~clk;

    smpc_core smpc_core_inst (
        .clk           (clk),
        .arst_n        (arst_n),
        .sleep_req     (sleep_req),
        .mod_disable   (mod_disable),
        .osc_sel       (osc_sel),
        .pb_keep_clk   (pb_keep_clk),
        .bor_en        (bor_en),
        .wdt_en        (wdt_en),
        .wdt_clear_req (wdt_clear_req),
        .wake_evt      (wake_evt),
        .bor_trip      (bor_trip),
        .gpio_level    (gpio_level),
        .gpio_drive    (gpio_drive),
        .cpu_halt      (cpu_halt),
        .in_sleep      (in_sleep),
        .sysclk_src_en (sysclk_src_en),
        .clock_failure_monitor_en       (clock_failure_monitor_en),
        .periph_clk_en (periph_clk_en),
        .wdt_run       (wdt_run),
        .wdt_clear     (wdt_clear),
        .bor_reset     (bor_reset),
        .wake_pulse    (wake_pulse),
        .gpio_pin_out  (gpio_pin_out),
        .gpio_pin_oe   (gpio_pin_oe)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic stop_test;
        $display("compared %0d mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Expected start-up wait per oscillator choice
    function automatic int start_cyc(input logic [1:0] o);
        case (o)
            2'h0:    return FAST_RC_START_CYC;
            2'h1:    return PRIMARY_START_CYC;
            2'h2:    return SECOND_START_CYC;
            default: return LOW_RC_START_CYC;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Pin traffic runs in every state, so sleep must not disturb it
    // ------------------------------------------------------------
    always @(posedge clk) begin
        lv_q       <= gpio_level;
        dv_q       <= gpio_drive;
        gpio_level <= 16'($urandom);
        gpio_drive <= 16'($urandom);
    end

    always @(negedge clk) begin
        if (pin_chk) begin
            `CHK(gpio_pin_out, lv_q);
            `CHK(gpio_pin_oe, dv_q);
        end
    end

    // ------------------------------------------------------------
    // One sleep and wake round with random settings
    // ------------------------------------------------------------
    task automatic sleep_round(input logic [1:0] o);
        logic [7:0] dis;
        logic [7:0] bad;
        logic       pk;
        logic       be;
        logic       we;
        int         w;
        int         k;
        dis = 8'($urandom);
        w = $urandom_range(6, 0);
        dis[w] = 1'b0;
        pk = 1'($urandom);
        be = 1'($urandom);
        we = 1'($urandom);
        @(posedge clk);
        mod_disable <= dis;
        osc_sel     <= o;
        pb_keep_clk <= pk;
        bor_en      <= be;
        wdt_en      <= we;
        cyc(2);
        `CHK(periph_clk_en, 8'(~dis));
        `CHK(wdt_run, we & ~dis[1]);
        // Entry
        @(posedge clk);
        sleep_req <= 1'b1;
        @(posedge clk);
        sleep_req <= 1'b0;
        @(negedge clk);
        `CHK(cpu_halt, 1'b1);
        `CHK(in_sleep, 1'b1);
        `CHK(clock_failure_monitor_en, 1'b0);
        `CHK(sysclk_src_en, pk);
        `CHK(periph_clk_en, WAKE_MASK_DEF & ~dis);
        `CHK(wdt_clear, 1'b0);
        `CHK(wdt_run, we & ~dis[1]);
        // Events from slots that cannot wake, and a supply dip
        bad = 8'h80 | (dis & 8'h7F);
        @(posedge clk);
        wake_evt <= bad;
        bor_trip <= 1'b1;
        cyc(5);
        `CHK(in_sleep, 1'b1);
        `CHK(bor_reset, be);
        @(posedge clk);
        wake_evt <= 8'h00;
        bor_trip <= 1'b0;
        cyc(5);
        `CHK(bor_reset, 1'b0);
        `CHK(in_sleep, 1'b1);
        // A real wake from a running slot
        @(posedge clk);
        wake_evt <= 8'(1 << w);
        k = 0;
        while (wake_pulse !== 1'b1 && k < 10) begin
            @(negedge clk);
            k++;
        end
        if (k >= 10) begin
            n_fail++;
            stop_test;
        end
        k = 0;
        while (cpu_halt === 1'b1 && k < 300) begin
            if (k > 0)
                `CHK(wake_pulse, 1'b0);
            `CHK(sysclk_src_en, 1'b1);
            `CHK(clock_failure_monitor_en, 1'b0);
            `CHK(in_sleep, 1'b0);
            @(negedge clk);
            k++;
        end
        `CHK(k, start_cyc(o) + 1);
        @(posedge clk);
        wake_evt <= 8'h00;
        cyc(1);
        `CHK(clock_failure_monitor_en, 1'b1);
        `CHK(sysclk_src_en, 1'b1);
        `CHK(periph_clk_en, 8'(~dis));
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h6f1475fc));
        arst_n        = 1'b0;
        sleep_req     = 1'b0;
        mod_disable   = 8'h00;
        osc_sel       = 2'h0;
        pb_keep_clk   = 1'b0;
        bor_en        = 1'b0;
        wdt_en        = 1'b0;
        wdt_clear_req = 1'b0;
        wake_evt      = 8'h00;
        bor_trip      = 1'b0;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        cyc(2);
        pin_chk = 1'b1;
        `CHK(cpu_halt, 1'b0);
        `CHK(clock_failure_monitor_en, 1'b1);
        `CHK(sysclk_src_en, 1'b1);
        `CHK(periph_clk_en, 8'hFF);
        // Software clear in run reaches the watchdog
        @(posedge clk);
        wdt_clear_req <= 1'b1;
        @(posedge clk);
        wdt_clear_req <= 1'b0;
        @(negedge clk);
        `CHK(wdt_clear, 1'b1);
        // Every oscillator choice, three times over
        for (int i = 0; i < 12; i++) begin
            sleep_round(2'(i));
        end
        stop_test;
    end

endmodule
